// >>> hw/cbtrx_core.sv
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RQ1: Triple sampling uses majority of three samples.
// RQ2: Phase one length is field plus one.
// RQ3: Phase two length is field plus one.
// RQ4: Bit time equals prescale times quanta count.
// RQ5: Timing registers writable only in soft reset.
// RQ6: Writing one clears flag, zero no effect.
// RQ7: Clear ignored while setting condition persists.
// RQ8: Flags cleared and held during soft reset.
// RQ9: Bus activity in sleep sets wake flag.
// RQ10: Inbound tally above 96 sets inbound warning.
// RQ11: Outbound tally above 96 sets outbound warning.
// RQ12: Inbound tally above 127 sets inbound passive.
// RQ13: Outbound tally above 127 sets outbound passive.
// RQ14: Outbound tally above 255 sets bus off.
// RQ15: Bus off clears after 128 idle runs.
// RQ16: Overrun sets sticky overrun flag.
// RQ17: Accepted message sets full; software clears it.
// RQ18: No buffer swap while full flag set.
// RQ19: Wake interrupt from wake flag and enable.
// RQ20: Receive interrupt from full flag and enable.
// RQ21: Error interrupt from enabled error flags.
// RQ22: Enables held reset during soft reset.
// RQ23: Prescaler divides clock by field plus one.
// RQ24: Bit is sync, phase one, phase two.
module cbtrx_core
  import cbtrx_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_pin,
  input wire logic sleep_mode,
  input wire logic [8:0] inbound_fault_tally,
  input wire logic [8:0] outbound_fault_tally,
  input wire logic overrun_event,
  input wire logic message_accepted,
  output logic buffer_swap,
  output logic sample_strobe,
  output logic sampled_bit,
  output logic wake_irq,
  output logic error_irq,
  output logic receive_irq
);

  logic soft_reset_bit_ff;
  logic [7:0] bus_timing_prescale_reg_ff;
  cbtrx_seg_t bus_timing_segments_ff;
  cbtrx_flags_t receiver_status_flags_ff;
  cbtrx_flags_t receiver_interrupt_enables_ff;
  cbtrx_flags_t set_cond;
  cbtrx_flags_t hold_cond;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;
  logic [5:0] quantum_cnt_ff;
  logic [3:0] phase_cnt_ff;
  cbtrx_phase_t phase_ff;
  logic [2:0] sample_hist_ff;
  logic sample_strobe_ff;
  logic sampled_bit_ff;
  logic [3:0] idle_run_ff;
  logic [7:0] recovery_cnt_ff;
  logic recovered;
  logic rx_prev_ff;
  logic tq_tick;
  logic wr_fire;
  logic timing_wr_ok;
  logic [7:0] clr_req;
  logic [5:0] err_pending;
  logic at_sample_point;

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic tally_above(input logic [8:0] t, input int lim);
    tally_above = (t > 9'(lim));
  endfunction

  function automatic logic reg_hit(input logic fire, input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = fire && (a == ofs);
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign wr_fire = wr_pend_ff;
  // Timing fields only move while the engine is parked, so no bit runs on half-written settings.
  assign timing_wr_ok = wr_fire & soft_reset_bit_ff; // RQ5
  // Writing zero to a flag position asks for nothing.
  assign clr_req = reg_hit(wr_fire, wr_addr_ff, CBTRX_OFS_FLAGS) ? hwdata[7:0] : 8'h00; // RQ6

  // Address phase latch; writes land in the data phase one cycle later.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= hsel & hready & htrans[1] & hwrite;
      wr_addr_ff <= haddr;
    end
  end

  // Reads are answered from a flop so data stands in the data phase.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (haddr)
      CBTRX_OFS_CTRL: nxt_rdata = {31'h0000_0000, soft_reset_bit_ff};
      CBTRX_OFS_PRESCALE: nxt_rdata = {24'h00_0000, bus_timing_prescale_reg_ff};
      CBTRX_OFS_SEGMENTS: nxt_rdata = {24'h00_0000, bus_timing_segments_ff};
      CBTRX_OFS_FLAGS: nxt_rdata = {24'h00_0000, receiver_status_flags_ff};
      CBTRX_OFS_ENABLES: nxt_rdata = {24'h00_0000, receiver_interrupt_enables_ff};
      // The tallies are read-only views of the counters kept outside this block.
      CBTRX_OFS_TALLY: nxt_rdata = {7'h00, outbound_fault_tally, 7'h00, inbound_fault_tally};
      CBTRX_OFS_STATUS: nxt_rdata = {30'h0000_0000, recovered, sleep_mode};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (hsel & hready & htrans[1] & ~hwrite) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      soft_reset_bit_ff <= CBTRX_CTRL_RESET;
    end else if (reg_hit(wr_fire, wr_addr_ff, CBTRX_OFS_CTRL)) begin
      soft_reset_bit_ff <= hwdata[0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus_timing_prescale_reg_ff <= CBTRX_PRESCALE_RESET;
      bus_timing_segments_ff <= CBTRX_SEGMENTS_RESET;
    end else if (timing_wr_ok) begin // RQ5
      if (wr_addr_ff == CBTRX_OFS_PRESCALE) begin
        bus_timing_prescale_reg_ff <= hwdata[7:0];
      end
      if (wr_addr_ff == CBTRX_OFS_SEGMENTS) begin
        bus_timing_segments_ff <= hwdata[7:0];
      end
    end
  end

  // Quantum clock: the six-bit field divides mclk by field plus one.
  // With a zero field the quantum ticks on every clock.
  assign tq_tick = (quantum_cnt_ff == bus_timing_prescale_reg_ff[5:0]); // RQ23 RQ4
  assign at_sample_point = (phase_ff == CBTRX_PH1) &&
    (phase_cnt_ff == bus_timing_segments_ff.first_phase_length); // RQ24

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      quantum_cnt_ff <= 6'h00;
    end else if (soft_reset_bit_ff || tq_tick) begin
      quantum_cnt_ff <= 6'h00;
    end else begin
      quantum_cnt_ff <= quantum_cnt_ff + 6'h01;
    end
  end

  // Invalid short segment codes are not trapped; the bit simply runs short.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= CBTRX_SYNC;
      phase_cnt_ff <= 4'h0;
    end else if (soft_reset_bit_ff) begin
      phase_ff <= CBTRX_SYNC;
      phase_cnt_ff <= 4'h0;
    end else if (tq_tick) begin
      unique case (phase_ff) // RQ24
        CBTRX_SYNC: begin
          phase_ff <= CBTRX_PH1;
          phase_cnt_ff <= 4'h0;
        end
        CBTRX_PH1: begin
          if (phase_cnt_ff == bus_timing_segments_ff.first_phase_length) begin // RQ2
            phase_ff <= CBTRX_PH2;
            phase_cnt_ff <= 4'h0;
          end else begin
            phase_cnt_ff <= phase_cnt_ff + 4'h1;
          end
        end
        CBTRX_PH2: begin
          if (phase_cnt_ff[2:0] == bus_timing_segments_ff.second_phase_length) begin // RQ3
            phase_ff <= CBTRX_SYNC;
            phase_cnt_ff <= 4'h0;
          end else begin
            phase_cnt_ff <= phase_cnt_ff + 4'h1;
          end
        end
        default: begin
          phase_ff <= CBTRX_SYNC;
          phase_cnt_ff <= 4'h0;
        end
      endcase
    end
  end

  // The sample history shifts once per quantum, so the two older taps sit before the sample point.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sample_hist_ff <= 3'h7;
      sample_strobe_ff <= 1'b0;
      sampled_bit_ff <= 1'b1;
    end else if (soft_reset_bit_ff) begin
      // Nothing is sampled while the engine is parked, and stale history is dropped.
      sample_strobe_ff <= 1'b0;
      sample_hist_ff <= 3'h7;
    end else begin
      sample_strobe_ff <= 1'b0;
      if (tq_tick) begin
        sample_hist_ff <= {sample_hist_ff[1:0], rx_pin};
        if (at_sample_point) begin
          sample_strobe_ff <= 1'b1;
          sampled_bit_ff <= bus_timing_segments_ff.triple_sampling ?
                            majority({sample_hist_ff[1:0], rx_pin}) : rx_pin; // RQ1
        end
      end
    end
  end

  assign sample_strobe = sample_strobe_ff;
  assign sampled_bit = sampled_bit_ff;

  // Bus-off recovery counts runs of eleven recessive bits while bus-off stands.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      idle_run_ff <= 4'h0;
      recovery_cnt_ff <= 8'h00;
    end else if (!receiver_status_flags_ff.bus_off_flag) begin
      idle_run_ff <= 4'h0;
      recovery_cnt_ff <= 8'h00;
    end else if (sample_strobe_ff) begin
      if (!sampled_bit_ff) begin
        idle_run_ff <= 4'h0;
      end else if (idle_run_ff == 4'(CBTRX_IDLE_BITS - 1)) begin
        idle_run_ff <= 4'h0;
        if (!recovered) begin
          recovery_cnt_ff <= recovery_cnt_ff + 8'h01; // RQ15
        end
      end else begin
        idle_run_ff <= idle_run_ff + 4'h1;
      end
    end
  end

  assign recovered = (recovery_cnt_ff == 8'(CBTRX_RECOVERY_RUNS));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= rx_pin;
    end
  end

  always_comb begin
    set_cond = '0;
    set_cond.wake_flag = sleep_mode & rx_prev_ff & ~rx_pin; // RQ9
    set_cond.inbound_warning_flag = tally_above(inbound_fault_tally, CBTRX_WARN_LIMIT) &
      ~receiver_status_flags_ff.inbound_passive_flag & ~receiver_status_flags_ff.outbound_passive_flag &
      ~receiver_status_flags_ff.bus_off_flag; // RQ10
    set_cond.outbound_warning_flag = tally_above(outbound_fault_tally, CBTRX_WARN_LIMIT) &
      ~receiver_status_flags_ff.inbound_passive_flag & ~receiver_status_flags_ff.outbound_passive_flag &
      ~receiver_status_flags_ff.bus_off_flag; // RQ11
    set_cond.inbound_passive_flag = tally_above(inbound_fault_tally, CBTRX_PASSIVE_LIMIT) &
      ~receiver_status_flags_ff.bus_off_flag; // RQ12
    set_cond.outbound_passive_flag = tally_above(outbound_fault_tally, CBTRX_PASSIVE_LIMIT) &
      ~receiver_status_flags_ff.bus_off_flag; // RQ13
    set_cond.bus_off_flag = tally_above(outbound_fault_tally, CBTRX_BUSOFF_LIMIT); // RQ14
    set_cond.overrun_flag = overrun_event; // RQ16
    set_cond.receive_buffer_full = message_accepted & ~receiver_status_flags_ff.receive_buffer_full; // RQ17
  end

  // A clear is refused while its cause persists; overrun and full have no lasting cause.
  always_comb begin
    hold_cond = '0;
    // Wake stays pending while the bus is still dominant in sleep.
    hold_cond.wake_flag = sleep_mode & ~rx_pin; // RQ7
    hold_cond.inbound_warning_flag = tally_above(inbound_fault_tally, CBTRX_WARN_LIMIT);
    hold_cond.outbound_warning_flag = tally_above(outbound_fault_tally, CBTRX_WARN_LIMIT);
    hold_cond.inbound_passive_flag = tally_above(inbound_fault_tally, CBTRX_PASSIVE_LIMIT);
    hold_cond.outbound_passive_flag = tally_above(outbound_fault_tally, CBTRX_PASSIVE_LIMIT);
    hold_cond.bus_off_flag = ~recovered; // RQ15
  end

  // The swap happens only into a released foreground buffer.
  assign buffer_swap = set_cond.receive_buffer_full; // RQ18

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      receiver_status_flags_ff <= CBTRX_FLAGS_RESET;
    end else if (soft_reset_bit_ff) begin
      receiver_status_flags_ff <= CBTRX_FLAGS_RESET; // RQ8
    end else begin
      // A set and a clear in one cycle leave the flag set, so no event is lost.
      for (int i = 0; i < 8; i++) begin
        if (set_cond[i]) begin
          receiver_status_flags_ff[i] <= 1'b1;
        end else if (clr_req[i] && !hold_cond[i]) begin // RQ6 RQ7
          receiver_status_flags_ff[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      receiver_interrupt_enables_ff <= CBTRX_ENABLES_RESET;
    end else if (soft_reset_bit_ff) begin
      // Enables park at zero so no interrupt escapes a soft reset.
      receiver_interrupt_enables_ff <= CBTRX_ENABLES_RESET; // RQ22
    end else if (reg_hit(wr_fire, wr_addr_ff, CBTRX_OFS_ENABLES)) begin
      receiver_interrupt_enables_ff <= hwdata[7:0];
    end
  end

  assign wake_irq = receiver_status_flags_ff.wake_flag & receiver_interrupt_enables_ff.wake_flag; // RQ19
  assign receive_irq = receiver_status_flags_ff.receive_buffer_full &
    receiver_interrupt_enables_ff.receive_buffer_full; // RQ20
  assign err_pending = receiver_status_flags_ff[6:1] & receiver_interrupt_enables_ff[6:1];
  assign error_irq = |err_pending; // RQ21

endmodule // cbtrx_core
`default_nettype wire

// >>> hw/cbtrx_pkg.sv
package cbtrx_pkg;
  localparam logic [7:0] CBTRX_OFS_CTRL = 8'h00;
  localparam logic [7:0] CBTRX_OFS_PRESCALE = 8'h04;
  localparam logic [7:0] CBTRX_OFS_SEGMENTS = 8'h08;
  localparam logic [7:0] CBTRX_OFS_FLAGS = 8'h0c;
  localparam logic [7:0] CBTRX_OFS_ENABLES = 8'h10;
  localparam logic [7:0] CBTRX_OFS_TALLY = 8'h14;
  localparam logic [7:0] CBTRX_OFS_STATUS = 8'h18;
  localparam logic CBTRX_CTRL_RESET = 1'b1;
  localparam logic [7:0] CBTRX_PRESCALE_RESET = 8'h00;
  localparam logic [7:0] CBTRX_SEGMENTS_RESET = 8'h00;
  localparam logic [7:0] CBTRX_FLAGS_RESET = 8'h00;
  localparam logic [7:0] CBTRX_ENABLES_RESET = 8'h00;
  localparam int CBTRX_WARN_LIMIT = 96;
  localparam int CBTRX_PASSIVE_LIMIT = 127;
  localparam int CBTRX_BUSOFF_LIMIT = 255;
  localparam int CBTRX_IDLE_BITS = 11;
  localparam int CBTRX_RECOVERY_RUNS = 128;
  localparam int CBTRX_PRESCALE_POS = 0;
  localparam int CBTRX_FIRST_PHASE_LENGTH_POS = 0;
  localparam int CBTRX_SECOND_PHASE_LENGTH_POS = 4;
  localparam int CBTRX_TRIPLE_SAMPLING_POS = 7;

  typedef struct packed {
    logic wake_flag;
    logic inbound_warning_flag;
    logic outbound_warning_flag;
    logic inbound_passive_flag;
    logic outbound_passive_flag;
    logic bus_off_flag;
    logic overrun_flag;
    logic receive_buffer_full;
  } cbtrx_flags_t;

  typedef struct packed {
    logic triple_sampling;
    logic [2:0] second_phase_length;
    logic [3:0] first_phase_length;
  } cbtrx_seg_t;

  typedef enum logic [1:0] {CBTRX_SYNC, CBTRX_PH1, CBTRX_PH2} cbtrx_phase_t;
endpackage

// >>> verif/cbtrx_bus_node.sv
`timescale 1ns/100ps
`default_nettype none
module cbtrx_bus_node (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [7:0] len,
  output logic rx_pin
);
  logic [7:0] cnt_ff;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) cnt_ff <= 8'h00;
    else if (go) cnt_ff <= len;
    else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
  end
  // The bus idles recessive between dominant bursts, as with the bus pull-up.
  assign rx_pin = (cnt_ff == 8'h00);
endmodule // cbtrx_bus_node
`default_nettype wire

// >>> verif/cbtrx_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cbtrx_checker
  import cbtrx_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rx_pin,
  input wire logic sleep_mode,
  input wire logic [8:0] outbound_fault_tally,
  input wire logic overrun_event,
  input wire logic message_accepted,
  input wire logic buffer_swap,
  input wire logic sample_strobe,
  input wire logic sampled_bit,
  input wire logic wake_irq,
  input wire logic error_irq,
  input wire logic receive_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Shadow of soft reset and enables, so flag effects can be tied to bus writes.
  logic ap_ff;
  logic [7:0] a_ff;
  logic soft_ff;
  logic [7:0] en_ff;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ap_ff <= 1'b0;
      a_ff <= 8'h00;
    end else if (hready) begin
      ap_ff <= hsel & htrans[1] & hwrite;
      a_ff <= haddr;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      soft_ff <= 1'b1;
      en_ff <= 8'h00;
    end else if (ap_ff && hready) begin
      if (a_ff == CBTRX_OFS_CTRL) soft_ff <= hwdata[0];
      if (a_ff == CBTRX_OFS_CTRL && hwdata[0]) en_ff <= 8'h00;
      if (a_ff == CBTRX_OFS_ENABLES && !soft_ff) en_ff <= hwdata[7:0];
    end
  end
  sequence wake_seen;
    ##[1:3] wake_irq;
  endsequence
  AST_OKAY_READY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_SOFT_QUIET: assert property (soft_ff && $past(soft_ff) |-> !(wake_irq || error_irq || receive_irq))
    else $error("interrupt during soft reset");
  AST_SOFT_IDLE: assert property (soft_ff && $past(soft_ff) |-> !sample_strobe)
    else $error("sampling during soft reset");
  AST_STROBE_PULSE: assert property (sample_strobe |=> !sample_strobe)
    else $error("sample strobe longer than one cycle");
  AST_SAMPLE_MOVE: assert property ($changed(sampled_bit) |-> sample_strobe)
    else $error("sample value moved off the sample point");
  AST_SWAP_BLOCK: assert property (receive_irq |-> !buffer_swap)
    else $error("buffer swap while full");
  AST_SWAP_CAUSE: assert property (buffer_swap |-> message_accepted)
    else $error("buffer swap without message");
  AST_RX_IRQ: assert property (buffer_swap && en_ff[0] && !soft_ff |=> receive_irq)
    else $error("no receive interrupt after swap");
  AST_OVR_IRQ: assert property (overrun_event && en_ff[1] && !soft_ff && !ap_ff |=> error_irq)
    else $error("no error interrupt after overrun");
  AST_BUSOFF_IRQ: assert property (outbound_fault_tally > 9'd255 && en_ff[2] && !soft_ff && !ap_ff
    |-> ##[1:2] error_irq)
    else $error("no error interrupt at bus off");
  AST_WAKE_IRQ: assert property (sleep_mode && $fell(rx_pin) && en_ff[7] && !soft_ff && !ap_ff
    |-> wake_seen)
    else $error("no wake interrupt on bus activity");
endmodule // cbtrx_checker
bind cbtrx_core cbtrx_checker u_chk (
  .mclk(mclk),
  .resetn(resetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .rx_pin(rx_pin),
  .sleep_mode(sleep_mode),
  .outbound_fault_tally(outbound_fault_tally),
  .overrun_event(overrun_event),
  .message_accepted(message_accepted),
  .buffer_swap(buffer_swap),
  .sample_strobe(sample_strobe),
  .sampled_bit(sampled_bit),
  .wake_irq(wake_irq),
  .error_irq(error_irq),
  .receive_irq(receive_irq)
);
`default_nettype wire

// >>> verif/tb_can_bit_timing_rx_status.sv
`timescale 1ns/100ps
`default_nettype none
module tb_can_bit_timing_rx_status;
  import cbtrx_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sleep_mode = 1'b0;
  logic [8:0] inbound_fault_tally = 9'h000;
  logic [8:0] outbound_fault_tally = 9'h000;
  logic overrun_event = 1'b0;
  logic message_accepted = 1'b0;
  logic go = 1'b0;
  wire hready, hreadyout, hresp, rx_pin, buffer_swap, sample_strobe;
  wire sampled_bit, wake_irq, error_irq, receive_irq;
  wire [31:0] hrdata;
  int num_errors = 0;
  int checks_done = 0;
  always #2 mclk = ~mclk;
  assign hready = hreadyout;
  cbtrx_core u_dut (
    .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_pin(rx_pin), .sleep_mode(sleep_mode), .inbound_fault_tally(inbound_fault_tally),
    .outbound_fault_tally(outbound_fault_tally), .overrun_event(overrun_event),
    .message_accepted(message_accepted), .buffer_swap(buffer_swap), .sample_strobe(sample_strobe),
    .sampled_bit(sampled_bit), .wake_irq(wake_irq), .error_irq(error_irq), .receive_irq(receive_irq)
  );
  cbtrx_bus_node u_node (.mclk(mclk), .resetn(resetn), .go(go), .len(8'h28), .rx_pin(rx_pin));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(n, q & m, e);
  endtask
  initial begin
    int i;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    rchk("ctrl", CBTRX_OFS_CTRL, 32'h1, 32'h1);
    rchk("prescale", CBTRX_OFS_PRESCALE, 32'hff, 32'h0);
    rchk("segments", CBTRX_OFS_SEGMENTS, 32'hff, 32'h0);
    rchk("flags", CBTRX_OFS_FLAGS, 32'hff, 32'h0);
    rchk("enables", CBTRX_OFS_ENABLES, 32'hff, 32'h0);
    rchk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
    wr(CBTRX_OFS_PRESCALE, 32'h02);
    wr(CBTRX_OFS_SEGMENTS, 32'hb4);
    wr(CBTRX_OFS_CTRL, 32'h0);
    wr(CBTRX_OFS_SEGMENTS, 32'h55);
    wr(CBTRX_OFS_PRESCALE, 32'h3f);
    rchk("segments", CBTRX_OFS_SEGMENTS, 32'hff, 32'hb4);
    rchk("prescale", CBTRX_OFS_PRESCALE, 32'h3f, 32'h02);
    // Divider 3, one sync plus five plus four quanta: thirty clocks per bit.
    for (int k = 0; k < 2; k++) begin
      i = 0;
      do begin @(negedge mclk); i++; end while (sample_strobe !== 1'b1 && i < 500);
    end
    chk("bit_cycles", i, 30);
    wr(CBTRX_OFS_ENABLES, 32'hff);
    rchk("enables", CBTRX_OFS_ENABLES, 32'hff, 32'hff);
    @(posedge mclk) overrun_event <= 1'b1;
    @(posedge mclk) overrun_event <= 1'b0;
    wr(CBTRX_OFS_FLAGS, 32'h0);
    rchk("overrun", CBTRX_OFS_FLAGS, 32'hff, 32'h02);
    chk("error_irq", error_irq, 1'b1);
    wr(CBTRX_OFS_FLAGS, 32'h02);
    rchk("overrun", CBTRX_OFS_FLAGS, 32'hff, 32'h0);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) message_accepted <= 1'b1;
      @(negedge mclk) chk("swap", buffer_swap, k == 0);
      @(posedge mclk) message_accepted <= 1'b0;
    end
    chk("receive_irq", receive_irq, 1'b1);
    rchk("full", CBTRX_OFS_FLAGS, 32'hff, 32'h01);
    wr(CBTRX_OFS_FLAGS, 32'h01);
    // Each warning and passive flag: a clear is refused above the limit, honoured at it.
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 2; j++) begin
        @(posedge mclk);
        if (k[0]) outbound_fault_tally <= 9'(j ? (k[1] ? 127 : 96) : (k[1] ? 130 : 100));
        else inbound_fault_tally <= 9'(j ? (k[1] ? 127 : 96) : (k[1] ? 130 : 100));
        wr(CBTRX_OFS_FLAGS, 32'hff);
        rchk("tally", CBTRX_OFS_TALLY, 32'h01ff01ff,
             {7'h00, outbound_fault_tally, 7'h00, inbound_fault_tally});
        rchk("err_flag", CBTRX_OFS_FLAGS, 32'h40 >> k, j ? 32'h0 : 32'h40 >> k);
      end
      @(posedge mclk);
      inbound_fault_tally <= 9'h000;
      outbound_fault_tally <= 9'h000;
    end
    @(posedge mclk) outbound_fault_tally <= 9'd300;
    @(posedge mclk) outbound_fault_tally <= 9'h000;
    wr(CBTRX_OFS_FLAGS, 32'hff);
    rchk("bus_off", CBTRX_OFS_FLAGS, 32'h04, 32'h04);
    repeat (44000) @(posedge mclk);
    rchk("recovered", CBTRX_OFS_STATUS, 32'h2, 32'h2);
    wr(CBTRX_OFS_FLAGS, 32'hff);
    rchk("bus_off", CBTRX_OFS_FLAGS, 32'h04, 32'h0);
    @(posedge mclk) sleep_mode <= 1'b1;
    @(posedge mclk) go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    repeat (60) @(posedge mclk);
    sleep_mode <= 1'b0;
    rchk("wake", CBTRX_OFS_FLAGS, 32'h80, 32'h80);
    chk("wake_irq", wake_irq, 1'b1);
    wr(CBTRX_OFS_FLAGS, 32'hff);
    rchk("flags", CBTRX_OFS_FLAGS, 32'hff, 32'h0);
    @(posedge mclk) overrun_event <= 1'b1;
    @(posedge mclk) overrun_event <= 1'b0;
    wr(CBTRX_OFS_CTRL, 32'h1);
    wr(CBTRX_OFS_ENABLES, 32'hff);
    rchk("flags", CBTRX_OFS_FLAGS, 32'hff, 32'h0);
    rchk("enables", CBTRX_OFS_ENABLES, 32'hff, 32'h0);
    chk("error_irq", error_irq, 1'b0);
    tally_and_finish();
  end
  initial begin
    repeat (80000) @(posedge mclk);
    num_errors++;
    tally_and_finish();
  end
endmodule // tb_can_bit_timing_rx_status
`default_nettype wire
